// ===== core/icache_pkg.sv
package icache_pkg;

  // Geometry of the cache
  localparam int CACHE_BYTES = 512;
  localparam int SEG_COUNT = 4;
  localparam int SEG_BYTES = 128;
  localparam int SUB_COUNT = 8;
  localparam int LW_PER_SUB = 4;
  localparam int LW_BITS = 32;
  localparam int LINE_COUNT = SEG_COUNT * SUB_COUNT * LW_PER_SUB;
  localparam int LINE_IDX_W = 7;

  // Field positions inside the bit-addressed program counter
  localparam int PC_W = 32;
  localparam int TAG_W = 22;
  localparam int TAG_LSB = 10;
  localparam int SUB_LSB = 7;
  localparam int LW_LSB = 5;
  localparam int HALF_BIT = 4;
  localparam int PC_ALIGN_BITS = 4;

  // Fill address on the multiplexed bus: 28-bit word address above 4 status bits
  localparam int WADDR_W = 28;
  localparam int STATUS_W = 4;
  localparam logic [3:0] FETCH_STATUS = 4'h0;
  localparam logic [1:0] LAST_LW = 2'h3;

  // Usage stack after reset: entry 0 is most recently used
  localparam logic [7:0] LRU_RESET = 8'he4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_LATCH = 2'b10,
    ST_DATA = 2'b11
  } fill_state_t;

  typedef struct packed {
    logic ack;
    logic [15:0] word;
  } fetch_rsp_t;

  typedef struct packed {
    logic [31:0] out;
    logic oe;
    logic strobe;
  } mem_drive_t;

  typedef logic [3:0][1:0] lru_stack_t;

  typedef struct packed {
    fill_state_t state;
    logic [3:0][TAG_W-1:0] tag;
    logic [3:0][7:0] present;
    logic [1:0] seg;
    logic [TAG_W-1:0] ftag;
    logic [2:0] fsub;
    logic [1:0] flw;
    logic fhalf;
    logic stale;
    logic [15:0] hold;
    fetch_rsp_t rsp;
    mem_drive_t drv;
  } cache_state_t;

endpackage : icache_pkg

// ===== core/instruction_cache_fetch.sv
`timescale 1ns/1ps
// Summary of operation
// - Cache holds 512 bytes as four segments of 128 bytes.
// - Each segment has a 22-bit start tag compared against fetch addresses.
// - Each segment has eight subsegments of four 32-bit long words.
// - Hit needs tag match and the addressed subsegment present flag set.
// - Memory fill starts only on a miss; hits use no memory access.
// - Allocation picks the least recently used segment from a four-entry stack.
// - A fill loads one whole subsegment, sets its flag; others stay unless a new tag clears them.
// - Loading and replacement are automatic; fetched words equal memory contents.
// - Program counter low four bit-address positions are always zero.
// - Fill drives a 28-bit word address valid at the strobe's falling edge.
// - Host control bit flushes the cache; host uses it after altering code.
module instruction_cache_fetch
  import icache_pkg::*;
#(
  parameter int SEGMENTS = SEG_COUNT,
  parameter int SUBSEGMENTS = SUB_COUNT
)(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fetch request from the execution section, held until acknowledged
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_pc,
  output logic fetch_ack,
  output logic [15:0] fetch_word,
  // Flush strobe from the host control register bit
  input wire logic cache_flush,
  // Multiplexed local address/data bus
  input wire logic [31:0] local_addr_data_bus_in,
  output logic [31:0] local_addr_data_bus_out,
  output logic local_addr_data_bus_oe,
  output logic address_latch_strobe,
  input wire logic narrow_bus_indicator_n,
  input wire logic mem_ready
);

  // The storage layout and the index widths are fixed to this geometry
  if (SEGMENTS != SEG_COUNT || SUBSEGMENTS != SUB_COUNT) begin : g_geom_check
    $error("cache geometry is fixed at four segments of eight subsegments");
  end

  // Whole sequencer state sits in one register
  cache_state_t st_reg;
  cache_state_t st_next;
  logic [LW_BITS-1:0] line_mem [LINE_COUNT];

  // Lookup, array and usage-stack signals
  logic [31:0] pc_aligned;
  logic [TAG_W-1:0] req_tag;
  logic [2:0] req_sub;
  logic [1:0] req_lw;
  logic req_half;
  logic [3:0] tag_hit;
  logic [3:0] seg_hit;
  logic hit;
  logic [1:0] hit_seg;
  logic reuse;
  logic [1:0] reuse_seg;
  logic [1:0] lru_seg;
  logic touch;
  logic [1:0] touch_seg;
  logic wr_en;
  logic [LINE_IDX_W-1:0] wr_idx;
  logic [LW_BITS-1:0] wr_data;
  logic [LW_BITS-1:0] rd_line;

  // Build the bus word: word address above the cycle status code
  function automatic logic [31:0] fill_addr(input logic [TAG_W-1:0] tag, input logic [2:0] sub,
                                            input logic [1:0] lw, input logic half);
    fill_addr = {tag, sub, lw, half, FETCH_STATUS};
  endfunction : fill_addr

  // Split the program counter; the bit-address part never takes part in a lookup
  always_comb begin
    pc_aligned = {fetch_pc[PC_W-1:PC_ALIGN_BITS], 4'h0};
    req_tag = pc_aligned[PC_W-1:TAG_LSB];
    req_sub = pc_aligned[TAG_LSB-1:SUB_LSB];
    req_lw = pc_aligned[SUB_LSB-1:LW_LSB];
    req_half = pc_aligned[HALF_BIT];
  end

  // Tag compare in all segments at once, gated by the subsegment flag
  always_comb begin
    hit_seg = 2'h0;
    reuse_seg = 2'h0;
    for (int i = 0; i < SEG_COUNT; i++) begin
      tag_hit[i] = st_reg.tag[i] == req_tag;
      seg_hit[i] = tag_hit[i] && st_reg.present[i][req_sub];
    end
    // Lowest index wins; live segments never share a tag, so order is moot
    for (int i = SEG_COUNT - 1; i >= 0; i--) begin
      if (seg_hit[i]) begin
        hit_seg = 2'(i);
      end
      if (tag_hit[i]) begin
        reuse_seg = 2'(i);
      end
    end
    hit = |seg_hit;
    reuse = |tag_hit;
  end

  // Array read port; its value only matters while hit is set
  assign rd_line = line_mem[{hit_seg, req_sub, req_lw}];

  // Fetch and fill sequencer
  always_comb begin
    st_next = st_reg;
    st_next.rsp.ack = 1'b0;
    touch = 1'b0;
    touch_seg = st_reg.seg;
    wr_en = 1'b0;
    wr_idx = {st_reg.seg, st_reg.fsub, st_reg.flw};
    wr_data = local_addr_data_bus_in;
    // A flush mid-fill marks the running fill so its data is not kept
    if (cache_flush) begin
      st_next.present = '0;
      st_next.stale = st_reg.state != ST_IDLE;
    end
    case (st_reg.state)
      ST_IDLE: begin
        // Any flush mark from the last fill is spent once the bus is idle
        st_next.stale = 1'b0;
        if (fetch_valid && !cache_flush) begin
          if (hit) begin
            // Served from the array, no bus cycle at all
            st_next.rsp.ack = 1'b1;
            st_next.rsp.word = req_half ? rd_line[31:16] : rd_line[15:0];
            touch = 1'b1;
            touch_seg = hit_seg;
          end else begin
            // Same region already held: fill the missing subsegment in place
            if (reuse) begin
              st_next.seg = reuse_seg;
            end else begin
              st_next.seg = lru_seg;
              st_next.present[lru_seg] = 8'h00;
              st_next.tag[lru_seg] = req_tag;
            end
            st_next.ftag = req_tag;
            st_next.fsub = req_sub;
            st_next.flw = 2'h0;
            st_next.fhalf = 1'b0;
            st_next.drv.out = fill_addr(req_tag, req_sub, 2'h0, 1'b0);
            st_next.drv.oe = 1'b1;
            st_next.drv.strobe = 1'b1;
            st_next.state = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        // Address stays on the bus across the falling strobe edge
        st_next.drv.strobe = 1'b0;
        st_next.state = ST_LATCH;
      end
      ST_LATCH: begin
        // Let go of the bus a cycle early so memory never fights the address
        st_next.drv.oe = 1'b0;
        st_next.drv.out = 32'h0;
        st_next.state = ST_DATA;
      end
      ST_DATA: begin
        if (mem_ready) begin
          if (!narrow_bus_indicator_n && !st_reg.fhalf) begin
            // 16-bit memory: even word first, then the odd word
            st_next.hold = local_addr_data_bus_in[15:0];
            st_next.fhalf = 1'b1;
            st_next.drv.out = fill_addr(st_reg.ftag, st_reg.fsub, st_reg.flw, 1'b1);
            st_next.drv.oe = 1'b1;
            st_next.drv.strobe = 1'b1;
            st_next.state = ST_ADDR;
          end else begin
            wr_en = 1'b1;
            if (st_reg.fhalf) begin
              wr_data = {local_addr_data_bus_in[15:0], st_reg.hold};
            end
            if (st_reg.flw == LAST_LW) begin
              // Whole subsegment in: only now does it count as present
              if (!st_reg.stale && !cache_flush) begin
                st_next.present[st_reg.seg][st_reg.fsub] = 1'b1;
              end
              touch = 1'b1;
              st_next.state = ST_IDLE;
            end else begin
              st_next.flw = st_reg.flw + 2'h1;
              st_next.fhalf = 1'b0;
              st_next.drv.out = fill_addr(st_reg.ftag, st_reg.fsub, st_reg.flw + 2'h1, 1'b0);
              st_next.drv.oe = 1'b1;
              st_next.drv.strobe = 1'b1;
              st_next.state = ST_ADDR;
            end
          end
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // State register; reset empties the cache like a flush
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Line storage has no reset: present flags decide what is valid
  always_ff @(posedge clk) begin
    if (wr_en) begin
      line_mem[wr_idx] <= wr_data;
    end
  end

  lru_stack u_lru (
    .clk(clk),
    .srst(srst),
    .touch(touch),
    .touch_seg(touch_seg),
    .lru_seg(lru_seg)
  );

  // Every output comes straight from a flip-flop
  assign fetch_ack = st_reg.rsp.ack;
  assign fetch_word = st_reg.rsp.word;
  assign local_addr_data_bus_out = st_reg.drv.out;
  assign local_addr_data_bus_oe = st_reg.drv.oe;
  assign address_latch_strobe = st_reg.drv.strobe;

  // Checks run on the core clock and rest while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence addr_phase;
    address_latch_strobe && local_addr_data_bus_oe ##1
      !address_latch_strobe && local_addr_data_bus_oe && $stable(local_addr_data_bus_out);
  endsequence

  // A lookup that finds its subsegment present
  sequence hit_seen;
    st_reg.state == ST_IDLE && fetch_valid && !cache_flush && hit;
  endsequence

  // A miss whose region has no segment yet: a victim is taken
  sequence alloc_miss;
    st_reg.state == ST_IDLE && fetch_valid && !cache_flush && !hit && !reuse;
  endsequence

  // A miss inside a region already held: the segment is filled in place
  sequence refill_miss;
    st_reg.state == ST_IDLE && fetch_valid && !cache_flush && !hit && reuse;
  endsequence

  chk_hit_no_bus: assert property (hit_seen |=> fetch_ack && !local_addr_data_bus_oe)
    else $error("hit did not answer without a bus cycle");
  chk_miss_starts_fill: assert property ($rose(address_latch_strobe) && $past(st_reg.state)
      == ST_IDLE |-> $past(!hit && fetch_valid))
    else $error("fill started without a miss");
  chk_addr_latch_edge: assert property ($rose(address_latch_strobe) |-> addr_phase)
    else $error("address not held across falling strobe");
  chk_addr_low_bits: assert property (local_addr_data_bus_oe |->
      local_addr_data_bus_out[3:0] == FETCH_STATUS
      && local_addr_data_bus_out[31:TAG_LSB] == st_reg.ftag)
    else $error("fill address malformed");
  chk_flush_clears: assert property (cache_flush |=> st_reg.present == '0)
    else $error("flush left a present flag set");
  chk_fill_sets_flag: assert property (st_reg.state == ST_DATA && wr_en
      && st_reg.flw == LAST_LW && !st_reg.stale && !cache_flush
      |=> st_reg.present[st_reg.seg][st_reg.fsub] && st_reg.state == ST_IDLE)
    else $error("completed fill did not mark its subsegment");
  chk_fill_tag_held: assert property (st_reg.state != ST_IDLE |->
      st_reg.tag[st_reg.seg] == st_reg.ftag)
    else $error("filling segment lost its tag");
  chk_ack_is_hit: assert property (fetch_ack |-> $past(hit && fetch_valid))
    else $error("answer given without a flagged hit");

  // Replacement choice and in-place refill
  chk_lru_victim: assert property (alloc_miss |=> st_reg.seg == $past(lru_seg))
    else $error("new region not placed in the least recently used segment");
  chk_refill_keeps_tags: assert property (refill_miss |=> $stable(st_reg.tag))
    else $error("refill of a held region replaced a tag");

  // Bus framing outside the address phase
  chk_strobe_one_cycle: assert property (address_latch_strobe |=> !address_latch_strobe)
    else $error("address strobe high for more than one cycle");
  chk_bus_idle_zero: assert property (!local_addr_data_bus_oe
      |-> local_addr_data_bus_out == 32'h0)
    else $error("bus output not quiet while released");

  // Flush against idle lookups and running fills
  chk_flush_blocks_lookup: assert property (st_reg.state == ST_IDLE && cache_flush
      |=> !fetch_ack && !address_latch_strobe)
    else $error("lookup went ahead in a flush cycle");
  chk_stale_fill_dropped: assert property (st_reg.state == ST_DATA && wr_en
      && st_reg.flw == LAST_LW && (st_reg.stale || cache_flush)
      |=> !st_reg.present[st_reg.seg][st_reg.fsub])
    else $error("fill cut by a flush was marked present");

endmodule : instruction_cache_fetch

// ===== core/lru_stack.sv
`timescale 1ns/1ps
module lru_stack
  import icache_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Usage update
  input wire logic touch,
  input wire logic [1:0] touch_seg,
  // Replacement choice
  output logic [1:0] lru_seg
);

  lru_stack_t stack_reg;
  lru_stack_t stack_next;
  logic [1:0] pos;

  // Move the touched segment to the top, entries above its old place slide down one place
  always_comb begin
    stack_next = stack_reg;
    pos = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (stack_reg[i] == touch_seg) begin
        pos = 2'(i);
      end
    end
    if (touch) begin
      for (int i = 1; i < 4; i++) begin
        if (2'(i) <= pos) begin
          stack_next[i] = stack_reg[i-1];
        end
      end
      stack_next[0] = touch_seg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stack_reg <= lru_stack_t'(LRU_RESET);
    end else begin
      stack_reg <= stack_next;
    end
  end

  assign lru_seg = stack_reg[3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_lru_top_update: assert property (touch |=> stack_reg[0] == $past(touch_seg))
    else $error("touched segment not at top of usage stack");
  chk_lru_distinct: assert property (stack_reg[0] != stack_reg[1]
      && stack_reg[0] != stack_reg[2] && stack_reg[0] != stack_reg[3]
      && stack_reg[1] != stack_reg[2] && stack_reg[1] != stack_reg[3]
      && stack_reg[2] != stack_reg[3])
    else $error("usage stack is not a permutation");
  chk_lru_no_touch: assert property (!touch |=> $stable(stack_reg))
    else $error("usage stack moved without a use");

endmodule : lru_stack

// ===== dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill bus from the cache
  input wire logic [31:0] bus_out,
  input wire logic bus_oe,
  input wire logic strobe,
  input wire logic narrow_n,
  // Knobs from the bench
  input wire logic [3:0] delay,
  input wire logic [31:0] gen,
  // Answer and trace
  output logic [31:0] bus_in,
  output logic mem_ready,
  output int n_addr,
  output logic [27:0] last_addr
);
  logic pend;
  logic [3:0] cnt;
  logic [31:0] lw;

  // Scrambled long words; gen stands for rewritten code
  function automatic logic [31:0] lw_val(input logic [26:0] la, input logic [31:0] g);
    return ({5'h0, la} * 32'h9e3779b1) ^ g;
  endfunction : lw_val

  assign lw = lw_val(last_addr[27:1], gen);

  // Latch each address phase, answer after a chosen wait
  always_ff @(posedge clk) begin
    mem_ready <= 1'b0;
    bus_in <= ~bus_in; // Idle bus never repeats old data
    if (srst) begin
      pend <= 1'b0;
      n_addr <= 0;
      last_addr <= 28'h0;
      bus_in <= 32'h5a5a_a5a5;
    end else if (strobe) begin
      pend <= 1'b1;
      cnt <= delay;
      last_addr <= bus_out[31:4];
      n_addr <= n_addr + 1;
    end else if (pend && !bus_oe) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0) begin
        pend <= 1'b0;
        mem_ready <= 1'b1;
        // Narrow memory answers on the low lines only
        bus_in <= narrow_n ? lw : {~bus_in[31:16], last_addr[0] ? lw[31:16] : lw[15:0]};
      end
    end
  end
endmodule : mem_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import icache_pkg::*;
  logic clk, srst, fv, ack, flush, oe, stb, nar_n, rdy;
  logic [31:0] pc, din, dout, gen;
  logic [15:0] word;
  logic [27:0] la;
  logic [3:0] dly;
  int n_addr, n_fail, compares, cyc, seed;
  int tg[4];
  bit pr[4][8];
  bit held;
  bit refill; // Set while a flush cuts the next fill, which then runs twice
  int lru[$];

  instruction_cache_fetch DUT (
    .clk(clk), .srst(srst), .fetch_valid(fv), .fetch_pc(pc), .fetch_ack(ack),
    .fetch_word(word), .cache_flush(flush), .local_addr_data_bus_in(din),
    .local_addr_data_bus_out(dout), .local_addr_data_bus_oe(oe),
    .address_latch_strobe(stb), .narrow_bus_indicator_n(nar_n), .mem_ready(rdy));

  mem_model mem (
    .clk(clk), .srst(srst), .bus_out(dout), .bus_oe(oe), .strobe(stb),
    .narrow_n(nar_n), .delay(dly), .gen(gen), .bus_in(din), .mem_ready(rdy),
    .n_addr(n_addr), .last_addr(la));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the planned run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Two-cycle reset; the reference forgets flags and usage
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    pr = '{default: 0};
    tg = '{default: 0};
    lru = '{0, 1, 2, 3};
  endtask : do_reset

  // One flush cycle with no request up
  task automatic do_flush();
    @(posedge clk);
    flush <= 1'b1;
    @(posedge clk);
    flush <= 1'b0;
    pr = '{default: 0};
  endtask : do_flush

  // One fetch; hold lets the next request follow the ack at once
  task automatic fetch(input logic [31:0] a, input bit nar, input bit hold);
    int s, i, n0;
    bit miss;
    logic [31:0] lw;
    s = -1;
    for (i = 0; i < 4; i++) begin
      if (tg[i] == a[31:10]) s = i;
    end
    miss = s < 0 || !pr[s][a[9:7]];
    if (s < 0) begin
      s = lru[3];
      tg[s] = a[31:10];
      pr[s] = '{default: 0};
    end
    pr[s][a[9:7]] = 1'b1;
    for (i = 0; i < lru.size(); i++) begin
      if (lru[i] == s) lru.delete(i);
    end
    lru.push_front(s);
    lw = mem.lw_val(a[31:5], gen);
    if (!held) @(posedge clk);
    held = hold;
    n0 = n_addr;
    nar_n <= !nar;
    dly <= 4'($urandom_range(0, 3));
    fv <= 1'b1;
    pc <= a | 32'($urandom_range(0, 15));
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (ack !== 1'b1 && i < 200);
    if (!hold) fv <= 1'b0;
    check("ack", 32'h1, {31'h0, ack});
    check("word", {16'h0, a[4] ? lw[31:16] : lw[15:0]}, {16'h0, word});
    check("fills", 32'(miss ? (nar ? 8 : 4) << refill : 0), 32'(n_addr - n0));
    if (miss) check("fill addr", {4'h0, a[31:7], 2'h3, nar}, {4'h0, la});
  endtask : fetch

  task automatic end_of_test();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    seed = $urandom(32'h11fca299);
    srst = 1'b1;
    fv = 1'b0;
    pc = 32'h0;
    flush = 1'b0;
    nar_n = 1'b1;
    dly = 4'h0;
    gen = 32'h3c5a0f11;
    do_reset();
    #1;
    check("reset outs", 32'h0, {ack, oe, stb, word, 13'h0});
    check("reset bus", 32'h0, dout);
    // Miss, hits in that subsegment back to back, narrow miss beside
    fetch(32'h0000_4400, 0, 0);
    fetch(32'h0000_4410, 0, 0);
    fetch(32'h0000_4460, 0, 1);
    fetch(32'h0000_4400, 0, 1);
    fetch(32'h0000_47f0, 1, 0);
    // Five new tags through four segments, then the evicted one again
    for (int k = 33; k <= 37; k++) begin
      fetch({22'(k), 10'h0}, 0, 0);
    end
    fetch({22'd33, 10'h0}, 0, 0);
    // Random mix of hits, refills, evictions and narrow fills
    for (int k = 0; k < 150; k++) begin
      fetch({22'($urandom_range(1, 6)), 3'($urandom_range(0, 2)), 2'($urandom_range(0, 3)),
        $urandom_range(0, 1) == 1, 4'h0}, $urandom_range(0, 3) == 0,
        $urandom_range(0, 3) == 0);
    end
    fetch({22'd1, 10'h0}, 0, 0);
    // Code rewritten, then flushed: refetch must miss and see new words
    gen = 32'h0f0f_a5c3;
    do_flush();
    fetch({22'd2, 10'h0}, 0, 0);
    fetch({22'd2, 10'h0}, 0, 0);
    // Reset in mid-run empties the cache too
    do_reset();
    fetch({22'd3, 10'h80}, 1, 0);
    // Flush while a fill runs: that fill is dropped and fetched again
    pr = '{default: 0};
    refill = 1'b1;
    fork
      fetch({22'd4, 10'h0}, 0, 0);
      begin
        repeat (3) @(posedge clk);
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
      end
    join
    refill = 1'b0;
    end_of_test();
  end
endmodule : tb_top
